/* File: pmc_cfg.svh */
/*
 Constants for the performance monitor control block: register numbers,
 field positions, reset values. Assumes the includer uses them as macros.
 Field positions are little-endian indices; the sign bit is index 31.
*/
// Contract
// [R1] Control word is 32 bits at register number 952.
// [R2] Control word reads and writes allowed only in supervisor mode.
// [R3] Control word is all zeros after reset.
// [R4] Reading the control word changes nothing.
// [R5] freeze_all_counting set stops hardware counter changes.
// [R6] freeze_in_privileged_mode set stops counting in supervisor mode.
// [R7] freeze_in_user_mode set stops counting in user mode.
// [R8] freeze_when_marked set stops counting while process mark set.
// [R9] freeze_when_unmarked set stops counting while process mark clear.
// [R10] pm_irq_allow gates all monitor interrupt signalling.
// [R11] Hardware clears pm_irq_allow whenever an interrupt is signalled.
// [R12] Software re-sets pm_irq_allow after service for more interrupts.
// [R13] Interrupt on enabled negative counter or enabled time base rise.
// [R14] halt_on_pm_irq freezes counter a, and b unless hold bit set.
// [R15] Software should clear timebase_edge_irq when it was set.
// [R16] timebase_bit_choice picks time base bit 63, 55, 51 or 47.
// [R17] timebase_edge_irq allows interrupt on selected bit rising.
// [R18] A counter is negative once its sign bit is set.
// [R19] counter_b_hold_until_a holds b until a negative or interrupt.
// [R20] counter_a_irq_enable enables interrupt on counter a negative.
// [R21] Counters advance only when no freeze condition is active.
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

`define PMC_SPR_CTRL        10'h3B8
`define PMC_SPR_CNT_A       10'h3B9
`define PMC_SPR_CNT_B       10'h3BA
`define PMC_CTRL_RESET      32'h0000_0000
`define PMC_CNT_RESET       32'h0000_0000

`define PMC_B_FREEZE_ALL    31
`define PMC_B_FREEZE_PRIV   30
`define PMC_B_FREEZE_USER   29
`define PMC_B_FREEZE_MARK   28
`define PMC_B_FREEZE_UNMARK 27
`define PMC_B_IRQ_ALLOW     26
`define PMC_B_HALT_ON_IRQ   25
`define PMC_B_TB_SEL_HI     24
`define PMC_B_TB_SEL_LO     23
`define PMC_B_TB_EDGE_IRQ   22
`define PMC_B_A_IRQ_EN      15
`define PMC_B_B_IRQ_EN      14
`define PMC_B_B_HOLD        13
`define PMC_B_SIGN          31

`define PMC_TB_IDX_SEL0     6'h00
`define PMC_TB_IDX_SEL1     6'h08
`define PMC_TB_IDX_SEL2     6'h0C
`define PMC_TB_IDX_SEL3     6'h10

`endif

/* File: pmc_core_model.sv */
/* Event source model standing in for the core pipeline.
   Assumes the bench raises en only between register accesses. */
`timescale 1ns/100ps
module pmc_core_model (
    input  wire logic        clk,
    input  wire logic        en,
    output      logic        ev_a,
    output      logic        ev_b,
    output      int unsigned n_a,
    output      int unsigned n_b
);
    logic go = 1'b0;
    logic ra, rb;
    initial {ev_a, ev_b, n_a, n_b} = '0;
    always @(posedge clk)
        go <= en;
    // Bursty random pulses, tallied so the bench knows what was offered
    always @(negedge clk) begin
        ra = go & 1'($urandom);
        rb = go & 1'($urandom);
        ev_a <= ra;
        ev_b <= rb;
        n_a <= n_a + ra;
        n_b <= n_b + rb;
    end
endmodule

/* File: pmc_counter.sv */
/*
 One 32-bit event counter with software load and gated increment.
 Assumes the caller resolves all freeze conditions into cnt_en.
*/
`timescale 1ns/100ps
`include "pmc_cfg.svh"

module pmc_counter (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             load,
    input  wire pmc_pkg::pmc_word_t load_data,
    input  wire logic             cnt_en,
    input  wire logic             event_in,
    output      pmc_pkg::pmc_word_t count
);
    pmc_pkg::pmc_word_t count_r;

    // Software load wins over an event in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_r <= `PMC_CNT_RESET;
        end else if (ce) begin
            if (load) begin
                count_r <= load_data;
            end else if (cnt_en && event_in) begin
                count_r <= count_r + 32'h0000_0001; // [R21]
            end
        end
    end

    assign count = count_r;
endmodule

/* File: pmc_ctrl.sv */
/*
 Performance monitor control: the control word, two event counters,
 freeze logic, interrupt signalling and time base edge watch.
 Assumes a core that presents register accesses as one-cycle strobes with
 a register number, and pre-selected event pulses for each counter.
*/
`timescale 1ns/100ps
`include "pmc_cfg.svh"

module pmc_ctrl (
    input  wire logic               CLOCK,
    input  wire logic               RST_N,
    input  wire logic               CE,
    input  wire pmc_pkg::pmc_spr_t  SPR_NUM,
    input  wire logic               SPR_RD,
    input  wire logic               SPR_WR,
    input  wire pmc_pkg::pmc_word_t SPR_WDATA,
    output      pmc_pkg::pmc_word_t SPR_RDATA,
    output      logic               SPR_ACK,
    output      logic               SPR_PRIV_FAULT,
    input  wire logic               USER_STATE_FLAG,
    input  wire logic               PROCESS_MARK_FLAG,
    input  wire logic               EVENT_A,
    input  wire logic               EVENT_B,
    input  wire logic [63:0]        TIME_BASE,
    output      logic               PM_IRQ,
    output      pmc_pkg::pmc_word_t COUNT_A,
    output      pmc_pkg::pmc_word_t COUNT_B
);

    pmc_pkg::pmc_word_t ctrl_r;
    pmc_pkg::pmc_word_t ctrl_nxt;
    pmc_pkg::pmc_word_t rdata_r;
    logic               ack_r;
    logic               fault_r;
    logic               irq_r;
    logic               tb_prev_r;
    logic               halted_r;
    logic               b_released_r;
    pmc_pkg::pmc_word_t count_a;
    pmc_pkg::pmc_word_t count_b;

    // Shared register-number decode
    function automatic logic spr_is(input pmc_pkg::pmc_spr_t num,
                                    input pmc_pkg::pmc_spr_t target);
        spr_is = (num == target);
    endfunction

    function automatic logic tb_pick(input logic [63:0] tb,
                                     input pmc_pkg::pmc_tb_sel_e sel);
        case (sel)
            pmc_pkg::PMC_TB_B63: tb_pick = tb[`PMC_TB_IDX_SEL0]; // [R16]
            pmc_pkg::PMC_TB_B55: tb_pick = tb[`PMC_TB_IDX_SEL1];
            pmc_pkg::PMC_TB_B51: tb_pick = tb[`PMC_TB_IDX_SEL2];
            default:             tb_pick = tb[`PMC_TB_IDX_SEL3];
        endcase
    endfunction

    // Access is honoured only in supervisor mode
    logic priv_ok;
    logic any_acc;
    logic known;
    logic wr_ctrl;
    logic wr_a;
    logic wr_b;
    assign priv_ok = !USER_STATE_FLAG; // [R2]
    assign any_acc = SPR_RD || SPR_WR;
    assign known   = spr_is(SPR_NUM, `PMC_SPR_CTRL) || spr_is(SPR_NUM, `PMC_SPR_CNT_A)
                     || spr_is(SPR_NUM, `PMC_SPR_CNT_B);
    assign wr_ctrl = SPR_WR && priv_ok && spr_is(SPR_NUM, `PMC_SPR_CTRL); // [R1] [R2]
    assign wr_a    = SPR_WR && priv_ok && spr_is(SPR_NUM, `PMC_SPR_CNT_A);
    assign wr_b    = SPR_WR && priv_ok && spr_is(SPR_NUM, `PMC_SPR_CNT_B);

    // Field views
    logic               f_freeze_all;
    logic               f_freeze_priv;
    logic               f_freeze_user;
    logic               f_freeze_mark;
    logic               f_freeze_unmark;
    logic               f_irq_allow;
    logic               f_halt_on_irq;
    logic               f_tb_edge_irq;
    logic               f_a_irq_en;
    logic               f_b_irq_en;
    logic               f_b_hold;
    pmc_pkg::pmc_tb_sel_e f_tb_sel;
    assign f_freeze_all    = ctrl_r[`PMC_B_FREEZE_ALL];
    assign f_freeze_priv   = ctrl_r[`PMC_B_FREEZE_PRIV];
    assign f_freeze_user   = ctrl_r[`PMC_B_FREEZE_USER];
    assign f_freeze_mark   = ctrl_r[`PMC_B_FREEZE_MARK];
    assign f_freeze_unmark = ctrl_r[`PMC_B_FREEZE_UNMARK];
    assign f_irq_allow     = ctrl_r[`PMC_B_IRQ_ALLOW];
    assign f_halt_on_irq   = ctrl_r[`PMC_B_HALT_ON_IRQ];
    assign f_tb_edge_irq   = ctrl_r[`PMC_B_TB_EDGE_IRQ];
    assign f_a_irq_en      = ctrl_r[`PMC_B_A_IRQ_EN];
    assign f_b_irq_en      = ctrl_r[`PMC_B_B_IRQ_EN];
    assign f_b_hold        = ctrl_r[`PMC_B_B_HOLD];
    assign f_tb_sel        = pmc_pkg::pmc_tb_sel_e'(ctrl_r[`PMC_B_TB_SEL_HI:`PMC_B_TB_SEL_LO]);

    // Negative counters and time base edge
    logic a_neg;
    logic b_neg;
    logic tb_bit;
    logic tb_rise;
    assign a_neg   = count_a[`PMC_B_SIGN]; // [R18]
    assign b_neg   = count_b[`PMC_B_SIGN]; // [R18]
    assign tb_bit  = tb_pick(TIME_BASE, f_tb_sel);
    assign tb_rise = tb_bit && !tb_prev_r && f_tb_edge_irq; // [R17]

    // Interrupt condition, gated by the allow bit
    logic irq_now;
    assign irq_now = f_irq_allow // [R10]
                     && ((f_a_irq_en && a_neg) // [R13] [R20]
                         || (f_b_irq_en && b_neg)
                         || tb_rise); // [R13]

    // Freeze terms common to both counters
    logic mode_freeze;
    assign mode_freeze = f_freeze_all // [R5]
                         || (f_freeze_priv && !USER_STATE_FLAG) // [R6]
                         || (f_freeze_user && USER_STATE_FLAG) // [R7]
                         || (f_freeze_mark && PROCESS_MARK_FLAG) // [R8]
                         || (f_freeze_unmark && !PROCESS_MARK_FLAG); // [R9]

    // Halt covers the interrupt cycle itself as well as later ones
    logic halt_now;
    logic hold_b;
    logic en_a;
    logic en_b;
    assign halt_now = f_halt_on_irq && (halted_r || irq_now); // [R14]
    assign hold_b   = f_b_hold && !(b_released_r || a_neg || irq_now); // [R19]
    assign en_a     = !mode_freeze && !halt_now; // [R21]
    assign en_b     = !mode_freeze && !hold_b && !(halt_now && !f_b_hold); // [R14] [R21]

    // Control word next value; the hardware clear of allow beats a write
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = SPR_WDATA; // [R12] [R15]
        end
        if (irq_now) begin
            ctrl_nxt[`PMC_B_IRQ_ALLOW] = 1'b0; // [R11]
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ctrl_r <= `PMC_CTRL_RESET; // [R3]
        end else if (CE) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Halt and b-release latches end on a fresh control word write
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            halted_r     <= 1'b0;
            b_released_r <= 1'b0;
        end else if (CE) begin
            if (irq_now) begin
                halted_r <= 1'b1;
            end else if (wr_ctrl) begin
                halted_r <= 1'b0;
            end
            if (irq_now || a_neg) begin
                b_released_r <= 1'b1; // [R19]
            end else if (wr_ctrl) begin
                b_released_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            tb_prev_r <= 1'b0;
            irq_r     <= 1'b0;
        end else if (CE) begin
            tb_prev_r <= tb_bit;
            irq_r     <= irq_now; // [R13]
        end
    end

    // Register reads: data from flip-flops, no side effect on storage
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            rdata_r <= 32'h0000_0000;
            ack_r   <= 1'b0;
            fault_r <= 1'b0;
        end else if (CE) begin
            ack_r   <= any_acc && known && priv_ok;
            fault_r <= any_acc && known && !priv_ok; // [R2]
            if (SPR_RD && priv_ok) begin
                if (spr_is(SPR_NUM, `PMC_SPR_CTRL)) begin
                    rdata_r <= ctrl_r; // [R4]
                end else if (spr_is(SPR_NUM, `PMC_SPR_CNT_A)) begin
                    rdata_r <= count_a;
                end else if (spr_is(SPR_NUM, `PMC_SPR_CNT_B)) begin
                    rdata_r <= count_b;
                end else begin
                    rdata_r <= 32'h0000_0000;
                end
            end
        end
    end

    pmc_counter u_cnt_a (
        .clk       (CLOCK),
        .rst_n     (RST_N),
        .ce        (CE),
        .load      (wr_a),
        .load_data (SPR_WDATA),
        .cnt_en    (en_a),
        .event_in  (EVENT_A),
        .count     (count_a)
    );

    pmc_counter u_cnt_b (
        .clk       (CLOCK),
        .rst_n     (RST_N),
        .ce        (CE),
        .load      (wr_b),
        .load_data (SPR_WDATA),
        .cnt_en    (en_b),
        .event_in  (EVENT_B),
        .count     (count_b)
    );

    assign SPR_RDATA      = rdata_r;
    assign SPR_ACK        = ack_r;
    assign SPR_PRIV_FAULT = fault_r;
    assign PM_IRQ         = irq_r;
    assign COUNT_A        = count_a;
    assign COUNT_B        = count_b;
endmodule

/* File: pmc_ctrl_monitor.sv */
/* Checker on pmc_ctrl ports: word access, refusals and counter freezes.
   Assumes binding to pmc_ctrl; keeps a shadow of the written word. */
`timescale 1ns/100ps
module pmc_ctrl_monitor (
    input wire logic        CLOCK,
    input wire logic        RST_N,
    input wire logic        CE,
    input wire logic [9:0]  SPR_NUM,
    input wire logic        SPR_RD,
    input wire logic        SPR_WR,
    input wire logic [31:0] SPR_WDATA,
    input wire logic [31:0] SPR_RDATA,
    input wire logic        SPR_ACK,
    input wire logic        SPR_PRIV_FAULT,
    input wire logic        USER_STATE_FLAG,
    input wire logic        PROCESS_MARK_FLAG,
    input wire logic [31:0] COUNT_A,
    input wire logic [31:0] COUNT_B
);
    logic [31:0] ctl_r;
    wire         usr = USER_STATE_FLAG;
    wire         mk  = PROCESS_MARK_FLAG;
    wire         ct  = SPR_NUM == 10'h3B8;
    wire         qt  = CE && !SPR_WR;
    wire  [63:0] cnt = {COUNT_A, COUNT_B};
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    always_ff @(posedge CLOCK) begin
        if (!RST_N)
            ctl_r <= '0;
        else if (CE && !usr && SPR_WR && ct)
            ctl_r <= SPR_WDATA;
    end
    a_freeze_all: assert property (qt && ctl_r[31] |=> $stable(cnt))
        else $error("count moved");
    a_freeze_priv: assert property (qt && ctl_r[30] && !usr |=> $stable(cnt))
        else $error("count moved");
    a_freeze_user: assert property (qt && ctl_r[29] && usr |=> $stable(cnt))
        else $error("count moved");
    a_freeze_mark: assert property (qt && ctl_r[28] && mk |=> $stable(cnt))
        else $error("count moved");
    a_freeze_unmark: assert property (qt && ctl_r[27] && !mk |=> $stable(cnt))
        else $error("count moved");
    a_write_taken: assert property (CE && !usr && SPR_WR && ct |=> SPR_ACK)
        else $error("write not taken");
    // Allow bit masked: hardware may clear it behind the shadow
    a_read_word: assert property (
        CE && !usr && SPR_RD && ct |=> SPR_ACK && ((SPR_RDATA ^ ctl_r) & 32'hFBFF_FFFF) == 0)
        else $error("read data wrong");
    a_user_refused: assert property (
        CE && usr && (SPR_RD || SPR_WR) && ct |=> SPR_PRIV_FAULT && !SPR_ACK)
        else $error("user access taken");
endmodule

bind pmc_ctrl pmc_ctrl_monitor u_mon (.CLOCK, .RST_N, .CE, .SPR_NUM, .SPR_RD, .SPR_WR,
    .SPR_WDATA, .SPR_RDATA, .SPR_ACK, .SPR_PRIV_FAULT, .USER_STATE_FLAG, .PROCESS_MARK_FLAG,
    .COUNT_A, .COUNT_B);

/* File: pmc_ctrl_tb_top.sv */
/* Self-checking bench for pmc_ctrl, with the event source model.
   Assumes the monitor is bound; inputs change at the falling edge. */
`timescale 1ns/100ps
module pmc_ctrl_tb_top;
    localparam logic [9:0] CT = 10'h3B8;
    logic        clock, rst_n, ce, rd, wr, usr, mk, en, ack, flt, irq, ev_a, ev_b;
    logic [9:0]  num;
    logic [31:0] wd, rdata, ca, cb, ctl;
    logic [63:0] tb;
    logic [33:0] q[$];
    int unsigned n_a, n_b, ea = 0, eb = 0, pa, pb, m = 0, ni = 0, i;
    int          n_mismatch = 0, comparisons = 0;
    pmc_ctrl DUT (.CLOCK(clock), .RST_N(rst_n), .CE(ce), .SPR_NUM(num), .SPR_RD(rd),
        .SPR_WR(wr), .SPR_WDATA(wd), .SPR_RDATA(rdata), .SPR_ACK(ack), .SPR_PRIV_FAULT(flt),
        .USER_STATE_FLAG(usr), .PROCESS_MARK_FLAG(mk), .EVENT_A(ev_a), .EVENT_B(ev_b),
        .TIME_BASE(tb), .PM_IRQ(irq), .COUNT_A(ca), .COUNT_B(cb));
    pmc_core_model P (.clk(clock), .en(en), .ev_a(ev_a), .ev_b(ev_b), .n_a(n_a), .n_b(n_b));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // x[33] fault, x[32] data checked, 2'b11 no answer expected
    task automatic acc(input logic w, input logic [9:0] n, input logic [31:0] d,
                       input logic [33:0] x);
        @(negedge clock);
        {wr, rd, num, wd} = {w, !w, n, d};
        if (x[33:32] != 2'b11)
            q.push_back(x);
    endtask
    task automatic idle(input int n);
        @(negedge clock);
        {rd, wr} = 2'b00;
        repeat (n) @(negedge clock);
    endtask
    task automatic wait_irq;
        int k;
        for (k = 0; k < 200 && ni == m; k++) @(negedge clock);
        m++;
        if (k == 200) begin
            n_mismatch++;
            report_and_stop;
        end
    endtask
    always @(negedge clock) begin
        if (irq === 1'b1)
            ni++;
        if (ack === 1'b1 || flt === 1'b1) begin
            cmp(q.size(), (q.size() == 0) ? 1 : q.size());
            if (q.size() != 0) begin
                cmp(flt, q[0][33]);
                if (q[0][32])
                    cmp(rdata, q[0][31:0]);
                void'(q.pop_front());
            end
        end
    end
    initial begin
        void'($urandom(90067));
        {rst_n, rd, wr, usr, mk, en, num, wd, tb} = '0;
        ce = 1'b1;
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        acc(0, CT, 0, {2'b01, 32'h0});
        acc(0, 10'h3B9, 0, {2'b01, 32'h0});
        ctl = $urandom & 32'hFBFF_FFFF;
        acc(1, CT, ctl, 0);
        acc(0, CT, 0, {2'b01, ctl});
        acc(0, CT, 0, {2'b01, ctl});
        idle(0);
        usr = 1'b1;
        acc(1, CT, 0, {2'b10, 32'h0});
        acc(0, CT, 0, {2'b10, 32'h0});
        idle(0);
        usr = 1'b0;
        acc(0, CT, 0, {2'b01, ctl});
        acc(0, 10'h3BB, 0, {2'b11, 32'h0});
        acc(1, 10'h3B9, 0, 0);
        acc(1, 10'h3BA, 0, 0);
        idle(2);
        cmp(rdata, 0);
        for (i = 0; i < 10; i++) begin
            acc(1, CT, (i == 5) ? 32'h0 : 32'h8000_0000 >> (i % 5), 0);
            idle(0);
            {usr, mk} = (i < 5) ? {i == 2, i == 3} : {i == 6, i == 9};
            {pa, pb, en} = {n_a, n_b, 1'b1};
            repeat (20) @(negedge clock);
            en = 1'b0;
            repeat (3) @(negedge clock);
            {usr, mk} = 2'b00;
            ea += (i >= 5) ? n_a - pa : 0;
            eb += (i >= 5) ? n_b - pb : 0;
            cmp(ca, ea);
            cmp(cb, eb);
        end
        // Clock enable low: events offered but nothing may move
        acc(1, CT, 32'h0, 0);
        idle(1);
        {ce, en} = 2'b01;
        repeat (20) @(negedge clock);
        en = 1'b0;
        repeat (2) @(negedge clock);
        ce = 1'b1;
        @(negedge clock);
        cmp(ca, ea);
        cmp(cb, eb);
        acc(1, 10'h3B9, 32'h7FFF_FFF0, 0);
        acc(1, CT, 32'h0600_8000, 0);
        idle(0);
        en = 1'b1;
        wait_irq;
        pb = cb;
        repeat (20) @(negedge clock);
        en = 1'b0;
        cmp(ca, 32'h8000_0000);
        cmp(cb, pb);
        acc(0, CT, 0, {2'b01, 32'h0200_8000});
        idle(8);
        cmp(ni, m);
        acc(1, CT, 32'h0400_8000, 0);
        idle(0);
        wait_irq;
        acc(1, 10'h3B9, 32'h7FFF_FFF8, 0);
        acc(1, 10'h3BA, 0, 0);
        acc(1, CT, 32'h0000_2000, 0);
        idle(0);
        en = 1'b1;
        for (i = 0; i < 200 && ca[31] !== 1'b1; i++) @(negedge clock);
        if (i == 200) begin
            n_mismatch++;
            report_and_stop;
        end
        cmp(cb, 0);
        repeat (30) @(negedge clock);
        en = 1'b0;
        cmp(cb != 0, 1);
        for (i = 0; i < 4; i++) begin
            tb = '0;
            acc(1, CT, 32'h0440_0000 | (i << 23), 0);
            idle(2);
            tb = 64'h2;
            repeat (3) @(negedge clock);
            cmp(ni, m);
            tb = tb | (64'h1 << ((i == 0) ? 0 : 4 * i + 4));
            wait_irq;
            acc(1, CT, 32'h0, 0);
            idle(3);
        end
        cmp(ni, m);
        cmp(q.size(), 0);
        report_and_stop;
    end
    initial begin
        #400000;
        n_mismatch++;
        report_and_stop;
    end
endmodule

/* File: pmc_pkg.sv */
/*
 Types shared by the performance monitor control block.
 Assumes pmc_cfg.svh supplies the numeric constants.
*/
package pmc_pkg;
    typedef logic [31:0] pmc_word_t;
    typedef logic [9:0]  pmc_spr_t;
    typedef enum logic [1:0] {
        PMC_TB_B63 = 2'h0,
        PMC_TB_B55 = 2'h1,
        PMC_TB_B51 = 2'h2,
        PMC_TB_B47 = 2'h3
    } pmc_tb_sel_e;
endpackage
